// ### hw/fpec_ctrl.sv
// flash program/erase controller with apb registers and memory port
`timescale 1ns/1ps
module fpec_ctrl #(
   parameter int unsigned PROG_CYCLES = fpec_pkg::PROG_CYC,
   parameter int unsigned BURST_CYCLES = fpec_pkg::BURST_CYC,
   parameter int unsigned PAGE_ERASE_CYCLES = fpec_pkg::PAGE_ERASE_CYC,
   parameter int unsigned MASS_ERASE_CYCLES = fpec_pkg::MASS_ERASE_CYC,
   parameter int unsigned ROW_MAX_CYCLES = fpec_pkg::ROW_MAX_CYC
) (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic mem_req,
   input wire logic mem_we,
   input wire logic [16:0] mem_addr,
   input wire logic [7:0] mem_wdata,
   output logic cpu_wait,
   output logic mem_done,
   output logic [16:0] fl_addr,
   output logic fl_info,
   output logic [7:0] fl_wdata,
   output logic fl_prog,
   output logic fl_hv,
   output logic fl_erase,
   output logic fl_mass,
   output logic fl_clk_en
);
   localparam int TW = fpec_pkg::TMR_W;
   localparam int RW = fpec_pkg::RTMR_W;

   typedef struct packed {
      fpec_pkg::fpec_state_t fsm;
      logic [TW-1:0] tmr;
      logic [RW-1:0] rtmr;
      logic brun;
      logic key_arm;
      logic unlocked;
      logic [7:0] data;
      logic [fpec_pkg::PAGE_W-1:0] page;
      logic [fpec_pkg::ROW_W-1:0] row;
      logic [fpec_pkg::COL_W-1:0] col;
      logic burst_en;
      logic info_sel;
      logic [7:0] fdiv;
      logic [7:0] prot;
      logic done;
      logic row_to;
      logic prot_err;
      logic apb_pend;
      logic mem_pend;
      logic [31:0] prdata;
      logic pready;
      logic pslverr;
      logic cpu_wait;
      logic mem_done;
      logic [16:0] fl_addr;
      logic fl_info;
      logic [7:0] fl_wdata;
      logic fl_prog;
      logic fl_hv;
      logic fl_erase;
      logic fl_mass;
   } fpec_st_t;

   fpec_st_t s_q;
   fpec_st_t s_d;
   logic acc;
   logic wr_done;
   logic mem_perr;
   logic [7:0] stat_v;

   // the top three page bits pick the 16 KB block; info page has no guard
   function automatic logic is_prot(input logic [7:0] prot,
                                    input logic [6:0] page,
                                    input logic info);
      is_prot = !info && prot[page[6:4]];
   endfunction : is_prot

   ////////////////////////////////////////////////////////////////////////
   fpec_fdiv u_fdiv (
      .pclk(pclk),
      .presetn(presetn),
      .div(s_q.fdiv),
      .tick(fl_clk_en)
   );

   assign acc = psel && penable && !s_q.pready;
   assign stat_v = {2'b00, s_q.unlocked, s_q.fl_hv,
                    s_q.fsm != fpec_pkg::FPEC_IDLE || s_q.brun,
                    s_q.prot_err, s_q.row_to, s_q.done};

   ////////////////////////////////////////////////////////////////////////
   always_comb begin
      s_d = s_q;
      s_d.pready = 1'b0;
      s_d.pslverr = 1'b0;
      s_d.mem_done = 1'b0;
      wr_done = 1'b0;
      mem_perr = 1'b0;
      // memory port first: it owns the array when both ask at once
      if (mem_req && !s_q.mem_pend && !s_q.mem_done) begin
         if (!mem_we) begin
            if (s_q.fsm == fpec_pkg::FPEC_ERASE) begin
               s_d.cpu_wait = 1'b1;
            end else begin
               s_d.cpu_wait = 1'b0;
               s_d.mem_done = 1'b1;
            end
         end else if (s_q.fsm == fpec_pkg::FPEC_IDLE && !s_q.brun) begin
            if (is_prot(s_q.prot, mem_addr[16:10], 1'b0)) begin
               // applied after the status clear so that the set wins
               mem_perr = 1'b1;
               s_d.cpu_wait = 1'b0;
               s_d.mem_done = 1'b1;
            end else begin
               // one byte only, burst control is ignored here
               s_d.fsm = fpec_pkg::FPEC_PROG;
               s_d.tmr = TW'(PROG_CYCLES - 1);
               s_d.fl_addr = mem_addr;
               s_d.fl_info = 1'b0;
               s_d.fl_wdata = mem_wdata;
               s_d.fl_prog = 1'b1;
               s_d.fl_hv = 1'b1;
               s_d.mem_pend = 1'b1;
               s_d.cpu_wait = 1'b1;
            end
         end else begin
            s_d.cpu_wait = 1'b1;
         end
      end
      // register bus
      if (acc && pwrite && paddr == fpec_pkg::OFS_DATA) begin
         // stays in the access phase until the array is free
         if (!s_q.apb_pend && s_q.fsm == fpec_pkg::FPEC_IDLE &&
             s_d.fsm == fpec_pkg::FPEC_IDLE) begin
            s_d.data = pwdata[7:0];
            wr_done = 1'b1;
            if (is_prot(s_q.prot, s_q.page, s_q.info_sel)) begin
               s_d.prot_err = 1'b1;
               s_d.pready = 1'b1;
               s_d.pslverr = 1'b1;
            end else begin
               s_d.fsm = fpec_pkg::FPEC_PROG;
               s_d.tmr = s_q.burst_en ? TW'(BURST_CYCLES - 1)
                                      : TW'(PROG_CYCLES - 1);
               s_d.fl_addr = {s_q.page, s_q.row, s_q.col};
               s_d.fl_info = s_q.info_sel;
               s_d.fl_wdata = pwdata[7:0];
               s_d.fl_prog = 1'b1;
               s_d.fl_hv = 1'b1;
               s_d.brun = s_q.burst_en;
               s_d.apb_pend = 1'b1;
            end
         end
      end else if (acc && pwrite) begin
         s_d.pready = 1'b1;
         wr_done = 1'b1;
         unique case (paddr)
            fpec_pkg::OFS_KEY: ;
            fpec_pkg::OFS_PAGE: s_d.page = pwdata[6:0];
            fpec_pkg::OFS_ROW: s_d.row = pwdata[2:0];
            fpec_pkg::OFS_COL: s_d.col = pwdata[6:0];
            fpec_pkg::OFS_PGCTL: begin
               s_d.burst_en = pwdata[fpec_pkg::PGC_BURST];
               s_d.info_sel = pwdata[fpec_pkg::PGC_INFO_SEL];
               if (s_q.fsm == fpec_pkg::FPEC_IDLE && !s_q.brun &&
                   s_d.fsm == fpec_pkg::FPEC_IDLE) begin
                  if (pwdata[fpec_pkg::PGC_MASS_ERASE]) begin
                     if (|s_q.prot) begin
                        s_d.prot_err = 1'b1;
                     end else begin
                        s_d.fsm = fpec_pkg::FPEC_ERASE;
                        s_d.tmr = TW'(MASS_ERASE_CYCLES - 1);
                        s_d.fl_mass = 1'b1;
                        s_d.fl_info = 1'b1;
                        s_d.fl_erase = 1'b1;
                        s_d.fl_wdata = fpec_pkg::ERASED_VAL;
                     end
                  end else if (pwdata[fpec_pkg::PGC_PAGE_ERASE]) begin
                     if (is_prot(s_q.prot, s_q.page,
                                 pwdata[fpec_pkg::PGC_INFO_SEL])) begin
                        s_d.prot_err = 1'b1;
                     end else begin
                        // page is the smallest unit erased
                        s_d.fsm = fpec_pkg::FPEC_ERASE;
                        s_d.tmr = TW'(PAGE_ERASE_CYCLES - 1);
                        s_d.fl_addr = {s_q.page, 10'h000};
                        s_d.fl_info = pwdata[fpec_pkg::PGC_INFO_SEL];
                        s_d.fl_erase = 1'b1;
                        s_d.fl_wdata = fpec_pkg::ERASED_VAL;
                     end
                  end
               end
            end
            fpec_pkg::OFS_STAT: begin
               if (pwdata[fpec_pkg::ST_DONE]) s_d.done = 1'b0;
               if (pwdata[fpec_pkg::ST_ROW_TO]) s_d.row_to = 1'b0;
               if (pwdata[fpec_pkg::ST_PROT_ERR]) s_d.prot_err = 1'b0;
            end
            fpec_pkg::OFS_FDIV: begin
               if (s_q.unlocked) s_d.fdiv = pwdata[7:0];
               s_d.unlocked = 1'b0;
            end
            fpec_pkg::OFS_PROT: begin
               s_d.prot = s_q.unlocked ? pwdata[7:0]
                                       : fpec_pkg::PROT_RST;
               s_d.unlocked = 1'b0;
            end
            default: s_d.pslverr = 1'b1;
         endcase
      end else if (acc) begin
         s_d.pready = 1'b1;
         s_d.prdata = 32'h0000_0000;
         unique case (paddr)
            fpec_pkg::OFS_KEY: ;
            fpec_pkg::OFS_DATA: s_d.prdata[7:0] = s_q.data;
            fpec_pkg::OFS_PAGE: s_d.prdata[6:0] = s_q.page;
            fpec_pkg::OFS_ROW: s_d.prdata[2:0] = s_q.row;
            fpec_pkg::OFS_COL: s_d.prdata[6:0] = s_q.col;
            fpec_pkg::OFS_PGCTL: begin
               s_d.prdata[fpec_pkg::PGC_BURST] = s_q.burst_en;
               s_d.prdata[fpec_pkg::PGC_INFO_SEL] = s_q.info_sel;
            end
            fpec_pkg::OFS_STAT: s_d.prdata[7:0] = stat_v;
            fpec_pkg::OFS_FDIV: s_d.prdata[7:0] = s_q.fdiv;
            fpec_pkg::OFS_PROT: s_d.prdata[7:0] = s_q.prot;
            default: s_d.pslverr = 1'b1;
         endcase
      end
      if (mem_perr) s_d.prot_err = 1'b1;
      // unlock needs the two key values in back-to-back writes; reads pass
      if (wr_done) begin
         s_d.key_arm = paddr == fpec_pkg::OFS_KEY &&
                       pwdata[7:0] == fpec_pkg::KEY_FIRST;
         if (s_q.key_arm && paddr == fpec_pkg::OFS_KEY &&
             pwdata[7:0] == fpec_pkg::KEY_SECOND) begin
            s_d.unlocked = 1'b1;
         end
      end
      // self-timed operations
      unique case (s_q.fsm)
         fpec_pkg::FPEC_IDLE: ;
         fpec_pkg::FPEC_PROG: begin
            s_d.tmr = s_q.tmr - TW'(1);
            if (s_q.tmr == '0) begin
               s_d.fsm = fpec_pkg::FPEC_IDLE;
               s_d.fl_prog = 1'b0;
               if (s_q.brun) begin
                  s_d.col = s_q.col + 7'h01;
                  if (s_q.col == fpec_pkg::LAST_COL) begin
                     s_d.fl_hv = 1'b0;
                     s_d.brun = 1'b0;
                     s_d.burst_en = 1'b0;
                  end
               end else begin
                  s_d.fl_hv = 1'b0;
               end
               if (s_q.apb_pend) begin
                  s_d.apb_pend = 1'b0;
                  s_d.pready = 1'b1;
               end
               if (s_q.mem_pend) begin
                  s_d.mem_pend = 1'b0;
                  s_d.cpu_wait = 1'b0;
                  s_d.mem_done = 1'b1;
               end
            end
         end
         fpec_pkg::FPEC_ERASE: begin
            s_d.tmr = s_q.tmr - TW'(1);
            if (s_q.tmr == '0) begin
               s_d.fsm = fpec_pkg::FPEC_IDLE;
               s_d.fl_erase = 1'b0;
               s_d.fl_mass = 1'b0;
               s_d.done = 1'b1;
            end
         end
      endcase
      // the whole row must finish inside the cumulative limit
      if (s_q.brun) begin
         s_d.rtmr = s_q.rtmr + RW'(1);
         if (s_q.rtmr == RW'(ROW_MAX_CYCLES - 1)) begin
            s_d.brun = 1'b0;
            s_d.burst_en = 1'b0;
            s_d.fl_hv = 1'b0;
            s_d.fl_prog = 1'b0;
            s_d.row_to = 1'b1;
            s_d.fsm = fpec_pkg::FPEC_IDLE;
            // a byte taken in this very cycle must be answered as well
            if (s_d.apb_pend) begin
               s_d.apb_pend = 1'b0;
               s_d.pready = 1'b1;
               s_d.pslverr = 1'b1;
            end
         end
      end else begin
         s_d.rtmr = '0;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         s_q <= '0;
         s_q.fsm <= fpec_pkg::FPEC_IDLE;
         s_q.fdiv <= fpec_pkg::FDIV_RST;
         s_q.prot <= fpec_pkg::PROT_RST;
      end else begin
         s_q <= s_d;
      end
   end

   assign prdata = s_q.prdata;
   assign pready = s_q.pready;
   assign pslverr = s_q.pslverr;
   assign cpu_wait = s_q.cpu_wait;
   assign mem_done = s_q.mem_done;
   assign fl_addr = s_q.fl_addr;
   assign fl_info = s_q.fl_info;
   assign fl_wdata = s_q.fl_wdata;
   assign fl_prog = s_q.fl_prog;
   assign fl_hv = s_q.fl_hv;
   assign fl_erase = s_q.fl_erase;
   assign fl_mass = s_q.fl_mass;

   ////////////////////////////////////////////////////////////////////////
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);

   property p_prog_unprot;
      $rose(s_q.fl_prog) |-> !is_prot(s_q.prot, s_q.fl_addr[16:10],
                                      s_q.fl_info);
   endproperty
   a_prog_unprot: assert property (p_prog_unprot)
      else $error("program started on a protected block");

   property p_single_len;
      $rose(s_q.fl_prog) && !s_q.brun |-> s_q.tmr == TW'(PROG_CYCLES - 1);
   endproperty
   a_single_len: assert property (p_single_len)
      else $error("single byte program length wrong");

   property p_burst_len;
      $rose(s_q.fl_prog) && s_q.brun |-> s_q.tmr == TW'(BURST_CYCLES - 1);
   endproperty
   a_burst_len: assert property (p_burst_len)
      else $error("burst byte program length wrong");

   property p_apb_stall;
      s_q.apb_pend |-> !s_q.pready && s_q.fl_prog;
   endproperty
   a_apb_stall: assert property (p_apb_stall)
      else $error("bus released before byte programmed");

   property p_hv_held;
      s_q.brun |-> s_q.fl_hv;
   endproperty
   a_hv_held: assert property (p_hv_held)
      else $error("high voltage dropped inside burst");

   property p_col_step;
      s_q.brun && s_q.fl_prog && s_q.tmr == '0 &&
      s_q.rtmr != RW'(ROW_MAX_CYCLES - 1)
      |=> s_q.col == $past(s_q.col) + 7'h01;
   endproperty
   a_col_step: assert property (p_col_step)
      else $error("column did not advance after burst byte");

   property p_mem_single;
      s_q.mem_pend |-> !s_q.brun;
   endproperty
   a_mem_single: assert property (p_mem_single)
      else $error("memory write entered burst");

   property p_row_to;
      s_q.brun && s_q.rtmr == RW'(ROW_MAX_CYCLES - 1)
      |=> s_q.row_to && !s_q.fl_hv && !s_q.brun;
   endproperty
   a_row_to: assert property (p_row_to)
      else $error("row time-out not handled");

   property p_mass_guard;
      $rose(s_q.fl_mass) |-> $past(s_q.prot) == 8'h00;
   endproperty
   a_mass_guard: assert property (p_mass_guard)
      else $error("mass erase with protection set");

   property p_lock_prot;
      acc && pwrite && paddr == fpec_pkg::OFS_PROT && !s_q.unlocked
      |=> s_q.prot == fpec_pkg::PROT_RST && !s_q.unlocked;
   endproperty
   a_lock_prot: assert property (p_lock_prot)
      else $error("locked protect write did not set all bits");

   property p_erase_wait;
      s_q.fsm == fpec_pkg::FPEC_ERASE && mem_req && !s_q.mem_done ##1
      s_q.fsm == fpec_pkg::FPEC_ERASE |-> s_q.cpu_wait && !s_q.mem_done;
   endproperty
   a_erase_wait: assert property (p_erase_wait)
      else $error("access completed during erase");

   c_burst_end: cover property (s_q.brun ##1 !s_q.brun && !s_q.row_to);
   c_mass: cover property ($rose(s_q.fl_mass));
   c_unlock: cover property ($rose(s_q.unlocked));
   c_mem_prog: cover property ($rose(s_q.mem_pend));
endmodule : fpec_ctrl

// ### hw/fpec_fdiv.sv
// flash controller clock enable divider
`timescale 1ns/1ps
module fpec_fdiv (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic [7:0] div,
   output logic tick
);
   typedef struct packed {
      logic [7:0] cnt;
      logic tick;
   } fpec_div_t;
   fpec_div_t s_q;
   fpec_div_t s_d;

   always_comb begin
      s_d = s_q;
      s_d.tick = 1'b0;
      // a divider of zero behaves as one
      if (s_q.cnt + 8'h01 >= div) begin
         s_d.cnt = 8'h00;
         s_d.tick = 1'b1;
      end else begin
         s_d.cnt = s_q.cnt + 8'h01;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         s_q <= '0;
      end else begin
         s_q <= s_d;
      end
   end

   assign tick = s_q.tick;
endmodule : fpec_fdiv

// ### hw/fpec_pkg.sv
// shared constants of the flash program/erase controller
package fpec_pkg;
   // apb register offsets (byte addresses)
   localparam logic [7:0] OFS_KEY = 8'h00;
   localparam logic [7:0] OFS_DATA = 8'h04;
   localparam logic [7:0] OFS_PAGE = 8'h08;
   localparam logic [7:0] OFS_ROW = 8'h0c;
   localparam logic [7:0] OFS_COL = 8'h10;
   localparam logic [7:0] OFS_PGCTL = 8'h14;
   localparam logic [7:0] OFS_STAT = 8'h18;
   localparam logic [7:0] OFS_FDIV = 8'h1c;
   localparam logic [7:0] OFS_PROT = 8'h20;
   // program_control_reg fields
   localparam int PGC_BURST = 0;
   localparam int PGC_PAGE_ERASE = 1;
   localparam int PGC_MASS_ERASE = 2;
   localparam int PGC_INFO_SEL = 3;
   // status fields
   localparam int ST_DONE = 0;
   localparam int ST_ROW_TO = 1;
   localparam int ST_PROT_ERR = 2;
   localparam int ST_BUSY = 3;
   localparam int ST_HV = 4;
   localparam int ST_UNLOCKED = 5;
   // array geometry
   localparam int PAGE_W = 7;
   localparam int ROW_W = 3;
   localparam int COL_W = 7;
   localparam int ADDR_W = PAGE_W + ROW_W + COL_W;
   localparam logic [COL_W-1:0] LAST_COL = 7'h7f;
   // values
   localparam logic [7:0] KEY_FIRST = 8'hb6;
   localparam logic [7:0] KEY_SECOND = 8'h49;
   localparam logic [7:0] PROT_RST = 8'hff;
   localparam logic [7:0] FDIV_RST = 8'h01;
   localparam logic [7:0] ERASED_VAL = 8'hff;
   // times and their cycle counts at 125 MHz
   localparam int CLK_NS = 8;
   localparam int PROG_MIN_NS = 66000;
   localparam int BURST_MIN_NS = 41000;
   localparam int PAGE_ERASE_NS = 10000000;
   localparam int MASS_ERASE_NS = 200000000;
   localparam int ROW_MAX_NS = 16000000;
   localparam int PROG_CYC = (PROG_MIN_NS + CLK_NS - 1) / CLK_NS;
   localparam int BURST_CYC = (BURST_MIN_NS + CLK_NS - 1) / CLK_NS;
   localparam int PAGE_ERASE_CYC = PAGE_ERASE_NS / CLK_NS;
   localparam int MASS_ERASE_CYC = MASS_ERASE_NS / CLK_NS;
   localparam int ROW_MAX_CYC = ROW_MAX_NS / CLK_NS;
   localparam int TMR_W = 25;
   localparam int RTMR_W = 21;
   typedef enum logic [2:0] {
      FPEC_IDLE = 3'b001,
      FPEC_PROG = 3'b010,
      FPEC_ERASE = 3'b100
   } fpec_state_t;
endpackage : fpec_pkg

// ### verif/fpec_cpu_model.sv
// cpu model issuing memory-space requests to the flash controller
`timescale 1ns/1ps
module fpec_cpu_model (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic go,
   input wire logic we,
   input wire logic [16:0] addr,
   input wire logic [7:0] wdata,
   output logic mem_req,
   output logic mem_we,
   output logic [16:0] mem_addr,
   output logic [7:0] mem_wdata,
   input wire logic mem_done
);
   initial begin
      mem_req = 1'b0;
      mem_we = 1'b0;
      mem_addr = 17'h00000;
      mem_wdata = 8'h00;
   end
   // held until done; released bus scrambled so stale values never match
   always @(posedge pclk) begin
      if (!presetn || (mem_req && mem_done)) begin
         mem_req <= 1'b0;
         mem_we <= ~mem_we;
         mem_addr <= ~mem_addr;
         mem_wdata <= ~mem_wdata;
      end else if (go && !mem_req) begin
         mem_req <= 1'b1;
         mem_we <= we;
         mem_addr <= addr;
         mem_wdata <= wdata;
      end
   end
endmodule : fpec_cpu_model

// ### verif/testbench.sv
// self-checking bench of the flash program/erase controller
`timescale 1ns/1ps
module testbench;
   logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0;
   logic pwrite = 1'b0, go = 1'b0, mwe = 1'b0, er;
   logic [7:0] paddr = 8'h00, mwd = 8'h00, dat, d_seen;
   logic [31:0] pwdata = 32'h0, prdata, rd, seed = 32'hddc2ddf9;
   logic [16:0] maddr = 17'h0, mem_addr, fl_addr, a_seen, ad;
   logic [7:0] mem_wdata, fl_wdata;
   logic [6:0] pg;
   logic pready, pslverr, mem_req, mem_we, cpu_wait, mem_done, fl_info;
   logic fl_prog, fl_hv, fl_erase, fl_mass, fl_clk_en;
   int fail_count = 0, num_checks = 0, cyc = 0, pcnt = 0, ecnt = 0, mcnt = 0;
   int wcnt = 0, tcnt = 0;
   logic i_seen;
   always #4 pclk = ~pclk;
   fpec_ctrl #(.PROG_CYCLES(20), .BURST_CYCLES(12), .PAGE_ERASE_CYCLES(50),
      .MASS_ERASE_CYCLES(80), .ROW_MAX_CYCLES(2000)) dut (
      .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .mem_req(mem_req),
      .mem_we(mem_we), .mem_addr(mem_addr), .mem_wdata(mem_wdata),
      .cpu_wait(cpu_wait), .mem_done(mem_done), .fl_addr(fl_addr),
      .fl_info(fl_info), .fl_wdata(fl_wdata), .fl_prog(fl_prog),
      .fl_hv(fl_hv), .fl_erase(fl_erase), .fl_mass(fl_mass),
      .fl_clk_en(fl_clk_en));
   fpec_cpu_model cpu (.pclk(pclk), .presetn(presetn), .go(go), .we(mwe),
      .addr(maddr), .wdata(mwd), .mem_req(mem_req), .mem_we(mem_we),
      .mem_addr(mem_addr), .mem_wdata(mem_wdata), .mem_done(mem_done));
   ////////////////////////////////////////////////////////////////////////
   function automatic logic [31:0] xs();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed;
   endfunction : xs
   // block 0 stays protected, so targets keep page[6:4] nonzero
   function automatic logic [6:0] free_page(logic [6:0] r);
      return {(r[6:4] == 3'h0) ? 3'h1 : r[6:4], r[3:0]};
   endfunction : free_page
   task automatic give_verdict();
      $display("checks %0d mismatches %0d", num_checks, fail_count);
      if (fail_count == 0 && num_checks > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask : give_verdict
   task automatic chk(string n, logic [31:0] got, logic [31:0] exp);
      num_checks++;
      if (got !== exp) begin
         fail_count++;
         $display("MISMATCH %s expected %h seen %h", n, exp, got);
      end
   endtask : chk
   task automatic apb(logic w, logic [7:0] a, logic [31:0] d);
      @(posedge pclk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do @(posedge pclk); while (pready !== 1'b1);
      rd = prdata;
      er = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask : apb
   task automatic unlock();
      apb(1'b1, fpec_pkg::OFS_KEY, 32'hb6);
      apb(1'b1, fpec_pkg::OFS_KEY, 32'h49);
   endtask : unlock
   task automatic mem(logic w, logic [16:0] a, logic [7:0] d);
      @(posedge pclk);
      go <= 1'b1;
      mwe <= w;
      maddr <= a;
      mwd <= d;
      @(posedge pclk);
      go <= 1'b0;
      do @(posedge pclk); while (mem_done !== 1'b1);
   endtask : mem
   always @(posedge pclk) begin
      cyc <= cyc + 1;
      if (fl_prog === 1'b1) begin
         pcnt <= pcnt + 1;
         a_seen <= fl_addr;
         d_seen <= fl_wdata;
         i_seen <= fl_info;
      end
      if (fl_erase === 1'b1) ecnt <= ecnt + 1;
      if (fl_mass === 1'b1) mcnt <= mcnt + 1;
      if (cpu_wait === 1'b1) wcnt <= wcnt + 1;
      if (cyc == 20000) begin
         fail_count++;
         give_verdict();
      end
   end
   ////////////////////////////////////////////////////////////////////////
   initial begin
      repeat (5) @(posedge pclk);
      presetn <= 1'b1;
      apb(1'b0, fpec_pkg::OFS_PROT, 0);
      chk("prot reset", rd, 32'hff);
      apb(1'b1, 8'h40, 0);
      chk("unmapped err", er, 1);
      apb(1'b1, fpec_pkg::OFS_KEY, 32'hb6);
      apb(1'b1, fpec_pkg::OFS_PAGE, 0);
      apb(1'b1, fpec_pkg::OFS_KEY, 32'h49);
      apb(1'b1, fpec_pkg::OFS_PROT, 0);
      apb(1'b0, fpec_pkg::OFS_PROT, 0);
      chk("split key", rd, 32'hff);
      unlock();
      apb(1'b1, fpec_pkg::OFS_FDIV, 32'h03);
      apb(1'b0, fpec_pkg::OFS_FDIV, 0);
      chk("fdiv write", rd, 32'h03);
      tcnt = 0;
      repeat (30) begin
         @(posedge pclk);
         if (fl_clk_en === 1'b1) tcnt++;
      end
      chk("clock enable", tcnt, 10);
      apb(1'b1, fpec_pkg::OFS_PROT, 0);
      apb(1'b0, fpec_pkg::OFS_PROT, 0);
      chk("relock", rd, 32'hff);
      unlock();
      apb(1'b1, fpec_pkg::OFS_PROT, 32'h01);
      $display("test keys done");
      for (int i = 0; i < 5; i++) begin
         pg = (i == 4) ? 7'h05 : free_page(7'(xs()));
         ad = (i == 0) ? 17'h1ffff : {pg, 10'(xs())};
         ad[16:10] = (i == 0) ? 7'h7f : pg;
         dat = 8'(xs());
         apb(1'b1, fpec_pkg::OFS_PAGE, ad[16:10]);
         apb(1'b1, fpec_pkg::OFS_ROW, ad[9:7]);
         apb(1'b1, fpec_pkg::OFS_COL, ad[6:0]);
         pcnt = 0;
         apb(1'b1, fpec_pkg::OFS_DATA, dat);
         chk("prog err", er, i == 4);
         chk("prog time", pcnt, (i == 4) ? 0 : 20);
         if (i < 4) chk("prog addr", a_seen, ad);
         if (i < 4) chk("prog data", d_seen, dat);
      end
      $display("test single program done");
      pg = free_page(7'(xs()));
      apb(1'b1, fpec_pkg::OFS_PAGE, pg);
      apb(1'b1, fpec_pkg::OFS_COL, 32'h7e);
      apb(1'b1, fpec_pkg::OFS_PGCTL, 32'h1);
      for (int i = 0; i < 2; i++) begin
         pcnt = 0;
         apb(1'b1, fpec_pkg::OFS_DATA, xs());
         chk("burst hv", fl_hv, i == 0);
         chk("burst time", pcnt, 12);
         chk("burst col", a_seen[6:0], 7'h7e + i);
      end
      apb(1'b0, fpec_pkg::OFS_PGCTL, 0);
      chk("burst end", rd[0], 0);
      $display("test burst done");
      // earlier refused program left the error flag set
      apb(1'b1, fpec_pkg::OFS_STAT, 32'h7);
      apb(1'b1, fpec_pkg::OFS_PGCTL, 32'h4);
      apb(1'b0, fpec_pkg::OFS_STAT, 0);
      chk("mass refused", rd[2], 1);
      chk("mass refused", mcnt, 0);
      apb(1'b1, fpec_pkg::OFS_STAT, 32'h7);
      ecnt = 0;
      apb(1'b1, fpec_pkg::OFS_PGCTL, 32'h2);
      apb(1'b0, fpec_pkg::OFS_STAT, 0);
      chk("erase busy", rd[3], 1);
      mem(1'b0, {pg, 10'h0}, 0);
      chk("erase wait", ecnt >= 50, 1);
      apb(1'b0, fpec_pkg::OFS_STAT, 0);
      chk("erase done", rd[0], 1);
      $display("test erase done");
      ad = {free_page(7'(xs())), 10'(xs())};
      dat = 8'(xs());
      pcnt = 0;
      wcnt = 0;
      mem(1'b1, ad, dat);
      chk("mem prog time", pcnt, 20);
      chk("mem prog addr", a_seen, ad);
      chk("mem prog data", d_seen, dat);
      chk("mem prog info", i_seen, 0);
      chk("mem stall", wcnt, 20);
      $display("test memory write done");
      apb(1'b1, fpec_pkg::OFS_PGCTL, 32'h1);
      apb(1'b1, fpec_pkg::OFS_DATA, xs());
      repeat (2000) @(posedge pclk);
      apb(1'b0, fpec_pkg::OFS_STAT, 0);
      chk("row time-out", rd[1], 1);
      chk("time-out hv", rd[4], 0);
      unlock();
      apb(1'b1, fpec_pkg::OFS_PROT, 0);
      apb(1'b1, fpec_pkg::OFS_PGCTL, 32'h4);
      mem(1'b0, 17'h00000, 8'h00);
      chk("mass time", mcnt, 80);
      $display("test time-out and mass erase done");
      give_verdict();
   end
endmodule : testbench
